// [logic/digital_lock_loop_loop_control.sv]
// loop control registers, phase detector divider, feedforward divider
// assumes reference pins asynchronous, feedback pulse on sys_clk
// Operation
// - detector sample clock is system clock / (4*field)
// - phase detector runs at half sample rate
// - single-tone bit outputs first tuning word open-loop
// - estimator fills estimate registers; bit four disables
// - bit zero closes loop, seeding from estimator
// - slew bit bounds tuning word change rate
// - polarity bit inverts loop response sign
// - divider is 16 bits, low byte first
// - divide ratio is value plus one
// - prescaler bit adds divide-by-two before divider
// - reset bits one, two clear integrator, filter
//
// Implementation choice: the strobed register port.
`timescale 1ns/10ps
`default_nettype none
module digital_lock_loop_loop_control
	import digital_lock_loop_ctrl_pkg::*;
(
	input  wire logic                      sys_clk,          // 125 MHz
	input  wire logic                      reset,            // async, high
	input  wire logic [digital_lock_loop_ctrl_pkg::ADDR_W-1:0] regAddr,   // reg address
	input  wire logic [digital_lock_loop_ctrl_pkg::DATA_W-1:0] regWrData, // write data
	input  wire logic                      regWrite,         // write strobe
	input  wire logic                      regRead,          // read strobe
	output logic [digital_lock_loop_ctrl_pkg::DATA_W-1:0] regRdData,      // read data
	input  wire logic                      referenceInputA,  // ref pin a
	input  wire logic                      referenceInputB,  // ref pin b
	input  wire logic                      referenceSelect,  // 1 = pin b
	input  wire logic                      feedbackPulse,    // fb divider
	output logic [digital_lock_loop_ctrl_pkg::FTW_W-1:0] tuningWord,      // to synth
	output logic                           feedforwardPulse, // divided ref
	output logic                           phaseDetectorTick,// pd strobe
	output logic                           loopClosed,       // mode closed
	output logic                           combIntegratorReset, // pulse
	output logic                           loopFilterReset   // pulse
);
	import digital_lock_loop_ctrl_pkg::*;

	// software registers
	logic [3:0]       pdDiv_r;                  // phase detector divider
	loop_ctrl_type    loopCtrl_r;               // loop control bits
	logic [FFD_W-1:0] ffDiv_r;                  // feedforward value
	logic             ffPrescale_r;             // extra divide-by-two
	logic             ffFalling_r;              // count falling edges
	logic [FTW_W-1:0] slewLimit_r;              // slew limit word
	logic [FTW_W-1:0] toneWord_r;               // first tuning word
	logic [FTW_W-1:0] estimate_r;               // frequency estimate

	// loop state
	loop_mode_type    mode_r;                   // operating mode
	logic [FTW_W-1:0] target_r;                 // loop filter integrator
	logic signed [15:0] phaseErr_r;             // comb integrator
	logic [FTW_W-1:0] periodCount_r;            // cycles since last pulse

	// access decode
	logic       wrHit;                          // any write
	logic [2:0] slewIdx;                        // byte within slew word
	logic [2:0] toneIdx;                        // byte within tone word
	logic [2:0] estIdx;                         // byte within estimate
	logic       inSlew;
	logic       inTone;
	logic       inEst;
	logic [DATA_W-1:0] rdNxt;                   // read mux

	assign wrHit   = regWrite;
	assign slewIdx = 3'(regAddr - OFS_SLEW_BASE);
	assign toneIdx = 3'(regAddr - OFS_TONE_BASE);
	assign estIdx  = 3'(regAddr - OFS_EST_BASE);
	assign inSlew  = (regAddr >= OFS_SLEW_BASE) &&
		(regAddr < OFS_SLEW_BASE + 10'(WORD_BYTES));
	assign inTone  = (regAddr >= OFS_TONE_BASE) &&
		(regAddr < OFS_TONE_BASE + 10'(WORD_BYTES));
	assign inEst   = (regAddr >= OFS_EST_BASE) &&
		(regAddr < OFS_EST_BASE + 10'(WORD_BYTES));

	// control register writes
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			pdDiv_r      <= PD_DIV_RST;
			loopCtrl_r   <= '0;
			ffDiv_r      <= FFD_RST;
			ffPrescale_r <= 1'b0;
			ffFalling_r  <= 1'b0;
		end else if (wrHit) begin
			unique case (regAddr)
				OFS_PD_DIV: begin
					pdDiv_r <= regWrData[3:0];
				end
				OFS_LOOP_CTRL: begin
					loopCtrl_r.singleTone       <= regWrData[BIT_TONE];
					loopCtrl_r.estimatorDisable <= regWrData[BIT_EST_DIS];
					loopCtrl_r.slewEnable       <= regWrData[BIT_SLEW];
					loopCtrl_r.polarity         <= regWrData[BIT_POLARITY];
					loopCtrl_r.closeLoop        <= regWrData[BIT_CLOSE];
				end
				OFS_FF_LOW: begin
					ffDiv_r[7:0] <= regWrData;
				end
				OFS_FF_HIGH: begin
					ffDiv_r[15:8] <= regWrData;
				end
				OFS_FF_PRESCALE: begin
					ffPrescale_r <= regWrData[BIT_PRESCALE];
					ffFalling_r  <= regWrData[BIT_FALLING];
				end
				default: begin
				end
			endcase
		end
	end

	// multi-byte words, lowest address holds least significant byte
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			slewLimit_r <= '0;
			toneWord_r  <= '0;
		end else if (wrHit) begin
			if (inSlew) begin
				slewLimit_r[slewIdx*8 +: 8] <= regWrData;
			end
			if (inTone) begin
				toneWord_r[toneIdx*8 +: 8] <= regWrData;
			end
		end
	end

	// self-clearing reset bits become one-cycle pulses
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			combIntegratorReset <= 1'b0;
			loopFilterReset     <= 1'b0;
		end else begin
			combIntegratorReset <= wrHit && (regAddr == OFS_RESET_PULSE) &&
				regWrData[BIT_RST_CCI];
			loopFilterReset     <= wrHit && (regAddr == OFS_RESET_PULSE) &&
				regWrData[BIT_RST_LF];
		end
	end

	// read mux; the reset register always reads zero
	always_comb begin
		rdNxt = '0;
		if (inEst) begin
			rdNxt = estimate_r[estIdx*8 +: 8];
		end else if (inSlew) begin
			rdNxt = slewLimit_r[slewIdx*8 +: 8];
		end else if (inTone) begin
			rdNxt = toneWord_r[toneIdx*8 +: 8];
		end else begin
			unique case (regAddr)
				OFS_PD_DIV:      rdNxt = {4'h0, pdDiv_r};
				OFS_LOOP_CTRL:   rdNxt = {2'b00, loopCtrl_r.singleTone,
					loopCtrl_r.estimatorDisable, loopCtrl_r.slewEnable,
					1'b0, loopCtrl_r.polarity, loopCtrl_r.closeLoop};
				OFS_FF_LOW:      rdNxt = ffDiv_r[7:0];
				OFS_FF_HIGH:     rdNxt = ffDiv_r[15:8];
				OFS_FF_PRESCALE: rdNxt = {ffFalling_r, 6'h00, ffPrescale_r};
				default:         rdNxt = '0;
			endcase
		end
	end

	// read data stands only in the cycle after the strobe
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			regRdData <= '0;
		end else begin
			regRdData <= regRead ? rdNxt : '0;
		end
	end

	// phase detector sample divider: ratio 4*field, zero taken as one
	logic [5:0] pdTerminal;                     // ratio minus one
	logic       sampleTick;                     // divided sampling clock
	logic       halfPhase_r;                    // halves the sample rate

	assign pdTerminal = (pdDiv_r == 4'h0) ? 6'(PD_MULT - 1) :
		6'(PD_MULT * pdDiv_r - 1);

	ratio_counter #(.WIDTH(6)) pdDivider (
		.sys_clk  (sys_clk),
		.reset    (reset),
		.advance  (1'b1),
		.terminal (pdTerminal),
		.tick     (sampleTick)
	);

	// every second sample strobes the phase detector
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			halfPhase_r       <= 1'b0;
			phaseDetectorTick <= 1'b0;
		end else begin
			if (sampleTick) begin
				halfPhase_r <= !halfPhase_r;
			end
			phaseDetectorTick <= sampleTick && halfPhase_r;
		end
	end

	// reference pins: two flops each before anything looks at them
	logic [1:0] refASync_r;
	logic [1:0] refBSync_r;
	logic [1:0] selSync_r;
	logic       refLevel_r;                     // chosen, edge-polarised
	logic       refPrev_r;
	logic       refEdge;
	logic       preToggle_r;                    // prescaler phase
	logic       ffAdvance;

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			refASync_r <= 2'b00;
			refBSync_r <= 2'b00;
			selSync_r  <= 2'b00;
			refLevel_r <= 1'b0;
			refPrev_r  <= 1'b0;
		end else begin
			refASync_r <= {refASync_r[0], referenceInputA};
			refBSync_r <= {refBSync_r[0], referenceInputB};
			selSync_r  <= {selSync_r[0], referenceSelect};
			refLevel_r <= (selSync_r[1] ? refBSync_r[1] : refASync_r[1]) ^
				ffFalling_r;
			refPrev_r  <= refLevel_r;
		end
	end

	// rising edge of the chosen, edge-polarised reference; limited to sys_clk/4 inputs
	assign refEdge   = refLevel_r && !refPrev_r;
	assign ffAdvance = refEdge && (!ffPrescale_r || preToggle_r);

	// divide-by-two prescaler ahead of the feedforward divider
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			preToggle_r <= 1'b0;
		end else if (refEdge && ffPrescale_r) begin
			preToggle_r <= !preToggle_r;
		end
	end

	// value plus one edges per pulse, zero gives divide-by-one
	ratio_counter #(.WIDTH(FFD_W)) ffDivider (
		.sys_clk  (sys_clk),
		.reset    (reset),
		.advance  (ffAdvance),
		.terminal (ffDiv_r),
		.tick     (feedforwardPulse)
	);

	// frequency estimator: system cycles per divided reference period
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			periodCount_r <= '0;
			estimate_r    <= '0;
		end else if (loopCtrl_r.estimatorDisable) begin
			periodCount_r <= '0;
		end else if (feedforwardPulse) begin
			estimate_r    <= periodCount_r;
			periodCount_r <= 48'h0000_0000_0001;
		end else begin
			periodCount_r <= periodCount_r + 1'b1;
		end
	end

	// mode: a closed loop outranks a tone left set by mistake
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			mode_r <= LOOP_OPEN;
		end else begin
			unique case (mode_r)
				LOOP_OPEN, LOOP_TONE: begin
					if (loopCtrl_r.closeLoop) begin
						mode_r <= LOOP_CLOSED;
					end else if (loopCtrl_r.singleTone) begin
						mode_r <= LOOP_TONE;
					end else begin
						mode_r <= LOOP_OPEN;
					end
				end
				LOOP_CLOSED: begin
					if (!loopCtrl_r.closeLoop) begin
						mode_r <= LOOP_OPEN;
					end
				end
				default: begin
					mode_r <= LOOP_OPEN;
				end
			endcase
		end
	end

	assign loopClosed = (mode_r == LOOP_CLOSED);

	// comb integrator: net phase lead since the last detector strobe
	logic [FTW_W-1:0] errExt;                   // sign-extended error
	assign errExt = {{(FTW_W-16){phaseErr_r[15]}}, phaseErr_r};

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			phaseErr_r <= '0;
		end else if (combIntegratorReset || phaseDetectorTick) begin
			phaseErr_r <= '0;
		end else begin
			phaseErr_r <= phaseErr_r + 16'(feedforwardPulse) -
				16'(feedbackPulse);
		end
	end

	// loop filter integrator feeding the tuning word
	logic closing;                              // entering closed mode
	assign closing = (mode_r != LOOP_CLOSED) && loopCtrl_r.closeLoop;

	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			target_r <= '0;
		end else if (loopFilterReset) begin
			target_r <= '0;
		end else if (closing) begin
			if (!loopCtrl_r.estimatorDisable) begin
				target_r <= estimate_r;
			end
		end else if (mode_r == LOOP_TONE) begin
			target_r <= toneWord_r;
		end else if (loopClosed && phaseDetectorTick) begin
			target_r <= loopCtrl_r.polarity ? target_r - errExt :
				target_r + errExt;
		end
	end

	slew_limiter #(.WIDTH(FTW_W)) outStage (
		.sys_clk (sys_clk),
		.reset   (reset),
		.enable  (loopCtrl_r.slewEnable),
		.step    (phaseDetectorTick),
		.target  (target_r),
		.limit   (slewLimit_r),
		.word    (tuningWord)
	);

	// checks
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (reset);

	sequence seqCloseEntry;
		closing && !loopCtrl_r.estimatorDisable && !loopFilterReset;
	endsequence

	sequence seqResetWrite;
		wrHit && (regAddr == OFS_RESET_PULSE) && regWrData[BIT_RST_CCI];
	endsequence

	AST_PD_SPACING: assert property (
		sampleTick |=> !sampleTick [*3])
		else $error("sample ticks closer than four cycles");
	AST_PD_HALF: assert property (
		phaseDetectorTick |=> !phaseDetectorTick [*7])
		else $error("detector strobe faster than half sample rate");
	AST_TONE_WORD: assert property (
		(mode_r == LOOP_TONE) && !loopFilterReset && !closing |=>
		target_r == $past(toneWord_r))
		else $error("tone mode not using first tuning word");
	AST_ESTIMATE: assert property (
		feedforwardPulse && !loopCtrl_r.estimatorDisable |=>
		estimate_r == $past(periodCount_r))
		else $error("estimate not captured");
	AST_CLOSE_SEED: assert property (
		seqCloseEntry |=> loopClosed && target_r == $past(estimate_r))
		else $error("closing did not seed from estimator");
	AST_SLEW_BOUND: assert property (
		loopCtrl_r.slewEnable && $past(loopCtrl_r.slewEnable) |->
		(tuningWord - $past(tuningWord) <= $past(slewLimit_r)) ||
		($past(tuningWord) - tuningWord <= $past(slewLimit_r)))
		else $error("tuning word moved faster than limit");
	AST_POLARITY: assert property (
		loopClosed && phaseDetectorTick && loopCtrl_r.polarity &&
		loopCtrl_r.closeLoop && !loopFilterReset |=>
		target_r == $past(target_r) - $past(errExt))
		else $error("inverted loop did not subtract error");
	AST_FF_HIGH: assert property (
		wrHit && regAddr == OFS_FF_HIGH |=>
		ffDiv_r[15:8] == $past(regWrData))
		else $error("high divider byte not stored");
	AST_RESET_PULSE: assert property (
		seqResetWrite |=> combIntegratorReset ##1 phaseErr_r == 16'h0000)
		else $error("integrator reset did not act");
endmodule : digital_lock_loop_loop_control
`default_nettype wire

// [logic/digital_lock_loop_ctrl_pkg.sv]
// package for the digital lock loop control and divider block
// assumes one system clock; register port is 10-bit address, 8-bit data
package digital_lock_loop_ctrl_pkg;

	localparam int ADDR_W = 10;                 // register address width
	localparam int DATA_W = 8;                  // register data width
	localparam int FTW_W  = 48;                 // tuning word width
	localparam int FFD_W  = 16;                 // feedforward divider width

	// register offsets
	localparam logic [ADDR_W-1:0] OFS_RESET_PULSE = 10'h012;
	localparam logic [ADDR_W-1:0] OFS_PD_DIV      = 10'h023;
	localparam logic [ADDR_W-1:0] OFS_LOOP_CTRL   = 10'h100;
	localparam logic [ADDR_W-1:0] OFS_FF_LOW      = 10'h101;
	localparam logic [ADDR_W-1:0] OFS_FF_HIGH     = 10'h102;
	localparam logic [ADDR_W-1:0] OFS_FF_PRESCALE = 10'h103;
	localparam logic [ADDR_W-1:0] OFS_EST_BASE    = 10'h115;
	localparam logic [ADDR_W-1:0] OFS_SLEW_BASE   = 10'h127;
	localparam logic [ADDR_W-1:0] OFS_TONE_BASE   = 10'h1A6;
	localparam int                WORD_BYTES      = 6;

	// field positions
	localparam int BIT_CLOSE     = 0;           // loop control
	localparam int BIT_POLARITY  = 1;
	localparam int BIT_SLEW      = 3;
	localparam int BIT_EST_DIS   = 4;
	localparam int BIT_TONE      = 5;
	localparam int BIT_PRESCALE  = 0;           // feedforward prescale reg
	localparam int BIT_FALLING   = 7;
	localparam int BIT_RST_CCI   = 1;           // self-clearing reset reg
	localparam int BIT_RST_LF    = 2;

	// phase detector divider scale
	localparam int PD_MULT = 4;

	// reset values
	localparam logic [3:0]       PD_DIV_RST = 4'h5;
	localparam logic [7:0]       CTRL_RST   = 8'h00;
	localparam logic [FFD_W-1:0] FFD_RST    = 16'h0000;

	// loop control bits as one carrier
	typedef struct packed {
		logic singleTone;
		logic estimatorDisable;
		logic slewEnable;
		logic polarity;
		logic closeLoop;
	} loop_ctrl_type;

	// loop operating mode
	typedef enum logic [1:0] {
		LOOP_OPEN   = 2'b00,
		LOOP_TONE   = 2'b01,
		LOOP_CLOSED = 2'b10
	} loop_mode_type;

endpackage : digital_lock_loop_ctrl_pkg

// [logic/ratio_counter.sv]
// modulo counter: one tick every terminal+1 advance cycles
// assumes advance comes from logic on sys_clk
`timescale 1ns/10ps
`default_nettype none
module ratio_counter #(
	parameter int WIDTH = 16                    // counter width
) (
	input  wire logic             sys_clk,      // system clock
	input  wire logic             reset,        // async reset, active high
	input  wire logic             advance,      // count one step
	input  wire logic [WIDTH-1:0] terminal,     // ratio minus one
	output logic                  tick          // one-cycle pulse
);
	logic [WIDTH-1:0] count_r;                  // position in the period

	// count up, wrap on terminal; a lowered terminal wraps at once
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			count_r <= '0;
		end else if (advance) begin
			if (count_r >= terminal) begin
				count_r <= '0;
			end else begin
				count_r <= count_r + 1'b1;
			end
		end
	end

	// registered tick keeps the output period constant
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			tick <= 1'b0;
		end else begin
			tick <= advance && (count_r >= terminal);
		end
	end
endmodule : ratio_counter
`default_nettype wire

// [logic/slew_limiter.sv]
// tuning word output stage with optional rate bound
// assumes step is a single-cycle pulse on sys_clk
`timescale 1ns/10ps
`default_nettype none
module slew_limiter #(
	parameter int WIDTH = 48                    // word width
) (
	input  wire logic             sys_clk,      // system clock
	input  wire logic             reset,        // async reset, active high
	input  wire logic             enable,       // bound the rate
	input  wire logic             step,         // update moment
	input  wire logic [WIDTH-1:0] target,       // wanted word
	input  wire logic [WIDTH-1:0] limit,        // largest change per step
	output logic      [WIDTH-1:0] word          // output word
);
	logic [WIDTH-1:0] upDiff;                   // target above word
	logic [WIDTH-1:0] downDiff;                 // word above target

	assign upDiff   = target - word;
	assign downDiff = word - target;

	// follow target, or move toward it by at most limit
	always_ff @(posedge sys_clk or posedge reset) begin
		if (reset) begin
			word <= '0;
		end else if (!enable) begin
			word <= target;                     // no bound: follow at once
		end else if (step) begin
			if (target > word) begin
				word <= word + ((upDiff > limit) ? limit : upDiff);
			end else begin
				word <= word - ((downDiff > limit) ? limit : downDiff);
			end
		end
	end
endmodule : slew_limiter
`default_nettype wire

// [dv/test_digital_lock_loop_loop_control.sv]
// self-checking bench for the loop control and divider block
// assumes the bench drives every port itself; no partner model
`timescale 1ns/10ps
`default_nettype none
module test_digital_lock_loop_loop_control
	import digital_lock_loop_ctrl_pkg::*;
;
	logic              system_clock;            // 125 MHz
	logic              rst;               // async, active high
	logic [ADDR_W-1:0] regAddr;           // register address
	logic [DATA_W-1:0] regWrData;         // write data
	logic              regWrite;          // write strobe
	logic              regRead;           // read strobe
	logic [DATA_W-1:0] regRdData;         // read data
	logic              reference_input_a;              // reference pin a
	logic              reference_input_b;              // reference pin b
	logic              refSel;            // 1 picks pin b
	logic              fbPulse;           // feedback divider pulse
	logic [FTW_W-1:0]  tuningWord;        // synth word
	logic              ffPulse;           // divided reference
	logic              pdTick;            // detector strobe
	logic              loopClosed;        // closed mode
	logic              cciRst;            // integrator reset pulse
	logic              lfRst;             // filter reset pulse
	logic [3:0]        refCnt;            // reference pattern counter
	logic [7:0]        rdVal;             // last read value
	int                errCount;          // mismatches
	int                nTests;            // comparisons
	int                ffCnt, pdCnt, cciCnt, lfCnt; // pulse tallies

	digital_lock_loop_loop_control u_digital_lock_loop_loop_control (
		.sys_clk            (system_clock),
		.reset              (rst),
		.regAddr            (regAddr),
		.regWrData          (regWrData),
		.regWrite           (regWrite),
		.regRead            (regRead),
		.regRdData          (regRdData),
		.referenceInputA    (reference_input_a),
		.referenceInputB    (reference_input_b),
		.referenceSelect    (refSel),
		.feedbackPulse      (fbPulse),
		.tuningWord         (tuningWord),
		.feedforwardPulse   (ffPulse),
		.phaseDetectorTick  (pdTick),
		.loopClosed         (loopClosed),
		.combIntegratorReset(cciRst),
		.loopFilterReset    (lfRst)
	);

	// clock, 8 ns period
	initial begin
		system_clock = 1'b0;
		forever #4 system_clock = ~system_clock;
	end

	// pin a period 8 cycles, pin b 16; well below sys_clk/4
	always @(posedge system_clock) begin
		refCnt <= refCnt + 4'h1;
		reference_input_a   <= refCnt[2];
		reference_input_b   <= refCnt[3];
	end

	// pulse tallies, cleared by the scenarios; sampled mid-cycle so that
	// the launching edge never races the count
	always @(negedge system_clock) begin
		if (ffPulse === 1'b1) ffCnt++;
		if (pdTick === 1'b1) pdCnt++;
		if (cciRst === 1'b1) cciCnt++;
		if (lfRst === 1'b1) lfCnt++;
	end

	task automatic checkVal(input logic [47:0] got, input logic [47:0] exp);
		nTests++;
		if (got !== exp) begin
			errCount++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask : checkVal

	task automatic checkRange(input int got, input int lo, input int hi);
		nTests++;
		if (got < lo || got > hi) begin
			errCount++;
			$display("Error %0t: count %0d not in %0d..%0d", $time, got, lo, hi);
		end
	endtask : checkRange

	// wait n cycles, then step past the edge updates
	task automatic run(input int n);
		repeat (n) @(posedge system_clock);
		#1;
	endtask : run

	// one-cycle write strobe
	task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
		@(posedge system_clock);
		regWrite  <= 1'b1;
		regAddr   <= a;
		regWrData <= d;
		@(posedge system_clock);
		regWrite  <= 1'b0;
	endtask : wr

	// one-cycle read strobe; data stand only in the following cycle
	task automatic rd(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
		@(posedge system_clock);
		regRead <= 1'b1;
		regAddr <= a;
		@(posedge system_clock);
		regRead <= 1'b0;
		#1;
		rdVal = regRdData;
		checkVal({40'h0, rdVal}, {40'h0, exp});
	endtask : rd

	// six bytes, lowest address carries the low byte
	task automatic wrWord(input logic [ADDR_W-1:0] b, input logic [47:0] w);
		for (int i = 0; i < WORD_BYTES; i++) wr(b + ADDR_W'(i), w[8*i +: 8]);
	endtask : wrWord

	task automatic resetValues();
		rd(OFS_PD_DIV, {4'h0, PD_DIV_RST});
		rd(OFS_LOOP_CTRL, CTRL_RST);
		rd(OFS_FF_LOW, FFD_RST[7:0]);
		rd(OFS_FF_HIGH, FFD_RST[15:8]);
		rd(10'h3F0, 8'h00);                  // unmapped reads zero
		wr(10'h3F0, 8'h5A);
		rd(10'h3F0, 8'h00);
		rd(OFS_RESET_PULSE, 8'h00);
	endtask : resetValues

	// count divided pulses over a window
	task automatic ffCase(input logic [15:0] v, input logic s, input logic p,
		input int win);
		int exp;
		wr(OFS_FF_LOW, v[7:0]);
		wr(OFS_FF_HIGH, v[15:8]);
		wr(OFS_FF_PRESCALE, {7'h00, p});
		@(posedge system_clock);
		refSel <= s;
		run(40);
		ffCnt = 0;
		run(win);
		exp = win / ((s ? 16 : 8) * (int'(v) + 1) * (p ? 2 : 1));
		checkRange(ffCnt, exp - 1, exp + 1);
	endtask : ffCase

	// falling-edge counting keeps the pulse rate of pin a
	task automatic fallCase();
		wr(OFS_FF_PRESCALE, 8'h80);
		rd(OFS_FF_PRESCALE, 8'h80);
		run(40);
		ffCnt = 0;
		run(240);
		checkRange(ffCnt, 29, 31);
		wr(OFS_FF_PRESCALE, 8'h00);
	endtask : fallCase

	// detector strobe every 2 * 4 * field cycles
	task automatic pdCase(input logic [3:0] d, input int win);
		wr(OFS_PD_DIV, {4'h0, d});
		run(130);
		pdCnt = 0;
		run(win);
		checkRange(pdCnt, win / (PD_MULT * int'(d) * 2) - 1,
			win / (PD_MULT * int'(d) * 2) + 1);
	endtask : pdCase

	// each reset bit pulses only its own output, once
	task automatic pulseCase(input logic [7:0] d);
		cciCnt = 0;
		lfCnt  = 0;
		wr(OFS_RESET_PULSE, d);
		run(4);
		checkRange(cciCnt, int'(d[1]), int'(d[1]));
		checkRange(lfCnt, int'(d[2]), int'(d[2]));
	endtask : pulseCase

	// loop behaviour: direction, polarity, slew, estimate, open-loop tone
	task automatic loopCase();
		logic [47:0] held;
		wr(OFS_LOOP_CTRL, 8'h10);
		wr(OFS_RESET_PULSE, 8'h06);
		run(5);
		checkVal(tuningWord, 48'h0);
		wrWord(OFS_SLEW_BASE, 48'h0000_0000_0001);
		wr(OFS_LOOP_CTRL, 8'h19);
		pdCnt = 0;
		run(320);
		checkVal({47'h0, loopClosed}, 48'h1);
		checkVal({16'h0, tuningWord[47:16]}, 48'h0);
		checkRange(int'(tuningWord[15:0]), 1, pdCnt + 1);
		wr(OFS_LOOP_CTRL, 8'h10);
		wr(OFS_RESET_PULSE, 8'h06);
		wr(OFS_LOOP_CTRL, 8'h13);
		run(200);
		checkVal({47'h0, tuningWord[47]}, 48'h1);
		wr(OFS_LOOP_CTRL, 8'h10);
		run(3);
		held = tuningWord;
		run(60);
		checkVal({47'h0, loopClosed}, 48'h0);
		checkVal(tuningWord, held);
		wr(OFS_RESET_PULSE, 8'hFF);
		wr(OFS_LOOP_CTRL, 8'h01);
		run(200);
		rd(OFS_EST_BASE, 8'h08);
		wr(OFS_EST_BASE, 8'hAA);
		rd(OFS_EST_BASE, 8'h08);
		rd(OFS_EST_BASE + 10'h001, 8'h00);
		// feedback outpacing the reference drives the word negative
		@(posedge system_clock);
		fbPulse <= 1'b1;
		run(200);
		checkVal({47'h0, tuningWord[47]}, 48'h1);
		@(posedge system_clock);
		fbPulse <= 1'b0;
		wr(OFS_LOOP_CTRL, 8'h00);
		wrWord(OFS_TONE_BASE, 48'h1234_5678_9ABC);
		wr(OFS_LOOP_CTRL, 8'h20);
		run(10);
		checkVal(tuningWord, 48'h1234_5678_9ABC);
		checkVal({47'h0, loopClosed}, 48'h0);
	endtask : loopCase

	task automatic wrapUp();
		$display("tests %0d errors %0d", nTests, errCount);
		if (errCount == 0 && nTests > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : wrapUp

	// watchdog: the sequence needs about 9200 cycles
	initial begin
		#400_000;
		errCount++;
		wrapUp();
	end

	// main sequence
	initial begin
		{rst, regWrite, regRead, refSel, fbPulse} = 5'b10000;
		regAddr = '0;
		regWrData = '0;
		refCnt = 4'h0;
		reference_input_a = 1'b0;
		reference_input_b = 1'b0;
		{errCount, nTests, ffCnt, pdCnt, cciCnt, lfCnt} = '0;
		repeat (4) @(posedge system_clock);
		rst <= 1'b0;
		resetValues();
		ffCase(16'h0100, 1'b0, 1'b0, 4112);
		ffCase(16'h0002, 1'b0, 1'b0, 240);
		ffCase(16'h0002, 1'b0, 1'b1, 480);
		ffCase(16'h0000, 1'b1, 1'b0, 240);
		ffCase(16'h0000, 1'b0, 1'b0, 240);
		fallCase();
		rd(OFS_FF_LOW, 8'h00);
		pdCase(4'h1, 320);
		pdCase(4'hF, 1200);
		pdCase(4'h2, 320);
		rd(OFS_PD_DIV, 8'h02);
		pulseCase(8'h02);
		pulseCase(8'h04);
		pulseCase(8'h06);
		loopCase();
		wrapUp();
	end
endmodule : test_digital_lock_loop_loop_control
`default_nettype wire
